// [ceacs_defines.svh]
`ifndef CEACS_DEFINES_SVH
`define CEACS_DEFINES_SVH
// Register byte addresses
`define CEACS_A_CMD 8'h00
`define CEACS_A_ARG 8'h04
`define CEACS_A_BLK 8'h08
`define CEACS_A_BYT 8'h0C
`define CEACS_A_CTRL 8'h10
`define CEACS_A_RINT 8'h14
`define CEACS_A_RESP 8'h18
`define CEACS_A_STAT 8'h1C
// Command control fields
`define CEACS_C_IDX 5:0
`define CEACS_C_RESP_EXP 6
`define CEACS_C_RESP_LONG 7
`define CEACS_C_CHK_CRC 8
`define CEACS_C_DATA_EXP 9
`define CEACS_C_WRITE 10
`define CEACS_C_WAIT_PRV 13
`define CEACS_C_CEATA_RD 22
`define CEACS_C_CCS_EXP 23
`define CEACS_C_START 31
// Control fields
`define CEACS_CT_SEND_CCSD 0
`define CEACS_CT_AUTO_STOP 1
// Raw event bits, write one to clear
`define CEACS_RI_BITS 6
`define CEACS_RI_DONE 0
`define CEACS_RI_CRC_ERR 1
`define CEACS_RI_ACD 2
`define CEACS_RI_DTO 3
`define CEACS_RI_CCS 4
`define CEACS_RI_RTO 5
// Frame constants
`define CEACS_BLK_MASK 32'h0000_FFFF
`define CEACS_FRAME_BITS 8'h30
`define CEACS_LONG_BITS 8'h88
`define CEACS_CRC_BITS 8'h28
`define CEACS_CCSD_BITS 8'h05
`define CEACS_CCSD_PAT 48'h0800_0000_0000
`define CEACS_STOP_IDX 6'h0C
`define CEACS_CRC_POLY 7'h09
`define CEACS_NCR_MAX 8'h40
`endif

// [ceacs_pkg.sv]
`include "ceacs_defines.svh"
package ceacs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_PRV, ST_SEND, ST_RESP, ST_WAIT_CCS, ST_CCSD, ST_STOP_SEND, ST_STOP_RESP
  } ceacs_state_t;

  typedef struct packed {
    ceacs_state_t state;
    logic [31:0] cmd;
    logic [31:0] arg;
    logic [31:0] blk;
    logic [31:0] byt;
    logic send_ccsd;
    logic auto_stop;
    logic [5:0] rint;
    logic [31:0] resp;
    logic prv_busy;
    logic [2:0] cclk_sync;
    logic [1:0] cmd_sync;
    logic [1:0] dat0_sync;
    logic [47:0] sh;
    logic [7:0] cnt;
    logic got_start;
    logic [6:0] crc;
    logic [7:0] wait_cnt;
    logic cmd_out;
    logic cmd_oe;
    logic data_start;
    logic data_write;
    logic ceata_read;
    logic [31:0] rd_data;
  } ceacs_regs_t;

  function automatic logic [6:0] ceacs_crc_step(input logic [6:0] c, input logic b);
    ceacs_crc_step = {c[5:0], 1'b0} ^ ((b ^ c[6]) ? `CEACS_CRC_POLY : 7'h00);
  endfunction

  function automatic logic [47:0] ceacs_frame(input logic [5:0] idx, input logic [31:0] arg);
    logic [39:0] f;
    logic [6:0] c;
    f = {2'b01, idx, arg};
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = ceacs_crc_step(c, f[i]);
    end
    ceacs_frame = {f, c, 1'b1};
  endfunction
endpackage

// [ceacs_sequencer.sv]
// Overview of operation
// - Direction bit 1 means write and 0 means read for the data phase.
// - Wait flag 0 sends at once; 1 holds until previous data is over.
// - Response CRC is checked only when the check flag is 1.
// - With the disable request set, the disable pattern goes to the card.
// - With auto stop also set, an internal stop follows and sets auto-done.
// - No CCS wait is made on commands that do not expect one.
`include "ceacs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ceacs_sequencer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic cclk,
  input wire logic cmd_in,
  output logic cmd_out,
  output logic cmd_oe,
  input wire logic dat0_in,
  input wire logic data_done,
  output logic data_start,
  output logic data_write,
  output logic ceata_read
);
  import ceacs_pkg::*;

  ceacs_regs_t r;
  ceacs_regs_t n;
  logic cclk_rise;
  logic cclk_fall;
  logic [47:0] cmd_frame;
  logic [47:0] stop_frame;

  assign cclk_rise = r.cclk_sync[1] & ~r.cclk_sync[2];
  assign cclk_fall = ~r.cclk_sync[1] & r.cclk_sync[2];
  assign cmd_frame = ceacs_frame(r.cmd[`CEACS_C_IDX], r.arg);
  assign stop_frame = ceacs_frame(`CEACS_STOP_IDX, 32'h0000_0000);

  always_comb begin
    logic [`CEACS_RI_BITS-1:0] set;
    logic [47:0] rx;
    logic [7:0] lim;
    set = '0;
    n = r;
    rx = {r.sh[46:0], r.cmd_sync[1]};
    lim = (r.state == ST_CCSD) ? `CEACS_CCSD_BITS : `CEACS_FRAME_BITS;
    n.cclk_sync = {r.cclk_sync[1:0], cclk};
    n.cmd_sync = {r.cmd_sync[0], cmd_in};
    n.dat0_sync = {r.dat0_sync[0], dat0_in};
    n.data_start = 1'b0;
    n.rd_data = 32'h0000_0000;
    n.data_write = r.cmd[`CEACS_C_WRITE];
    n.ceata_read = r.cmd[`CEACS_C_CEATA_RD];
    if (rd_stb) begin
      unique case (addr)
        `CEACS_A_CMD: n.rd_data = r.cmd;
        `CEACS_A_ARG: n.rd_data = r.arg;
        `CEACS_A_BLK: n.rd_data = r.blk;
        `CEACS_A_BYT: n.rd_data = r.byt;
        `CEACS_A_CTRL: n.rd_data = {30'h0000_0000, r.auto_stop, r.send_ccsd};
        `CEACS_A_RINT: n.rd_data = {26'h000_0000, r.rint};
        `CEACS_A_RESP: n.rd_data = r.resp;
        `CEACS_A_STAT: n.rd_data = {27'h000_0000, r.prv_busy, r.state};
        default: n.rd_data = 32'h0000_0000;
      endcase
    end
    if (wr_stb) begin
      unique case (addr)
        `CEACS_A_CMD: if (r.state == ST_IDLE && !r.cmd[`CEACS_C_START]) n.cmd = wdata;
        `CEACS_A_ARG: n.arg = wdata;
        `CEACS_A_BLK: n.blk = wdata & `CEACS_BLK_MASK;
        `CEACS_A_BYT: n.byt = wdata;
        `CEACS_A_CTRL: begin
          n.send_ccsd = wdata[`CEACS_CT_SEND_CCSD];
          n.auto_stop = wdata[`CEACS_CT_AUTO_STOP];
        end
        `CEACS_A_RINT: n.rint = r.rint & ~wdata[`CEACS_RI_BITS-1:0];
        default: ;
      endcase
    end
    if (data_done) begin
      set[`CEACS_RI_DTO] = 1'b1;
      n.prv_busy = 1'b0;
    end
    unique case (r.state)
      ST_IDLE, ST_WAIT_PRV: begin
        if (r.cmd[`CEACS_C_START]) begin
          if (r.cmd[`CEACS_C_WAIT_PRV] && r.prv_busy) begin
            n.state = ST_WAIT_PRV;
          end else begin
            n.state = ST_SEND;
            n.sh = cmd_frame;
            n.cnt = 8'h00;
          end
        end
      end
      ST_SEND, ST_CCSD, ST_STOP_SEND: begin
        if (cclk_fall) begin
          if (r.cnt == lim) begin
            n.cmd_oe = 1'b0;
            n.cmd_out = 1'b1;
            n.cnt = 8'h00;
            n.got_start = 1'b0;
            n.wait_cnt = 8'h00;
            n.crc = 7'h00;
            if (r.state == ST_SEND) begin
              n.cmd[`CEACS_C_START] = 1'b0;
              if (r.cmd[`CEACS_C_RESP_EXP]) begin
                n.state = ST_RESP;
              end else begin
                n.state = ST_IDLE;
                set[`CEACS_RI_DONE] = 1'b1;
              end
            end else if (r.state == ST_CCSD && r.auto_stop) begin
              n.state = ST_STOP_SEND;
              n.sh = stop_frame;
            end else if (r.state == ST_CCSD) begin
              n.state = ST_IDLE;
              n.send_ccsd = 1'b0;
              set[`CEACS_RI_DONE] = 1'b1;
            end else begin
              n.state = ST_STOP_RESP;
            end
          end else begin
            n.cmd_oe = 1'b1;
            n.cmd_out = r.sh[47];
            n.sh = {r.sh[46:0], 1'b1};
            n.cnt = r.cnt + 8'h01;
          end
        end
      end
      ST_RESP, ST_STOP_RESP: begin
        if (cclk_rise) begin
          if (!r.got_start) begin
            if (!r.cmd_sync[1]) begin
              n.got_start = 1'b1;
              n.sh = rx;
              n.cnt = 8'h01;
              n.crc = ceacs_crc_step(7'h00, 1'b0);
            end else if (r.wait_cnt == `CEACS_NCR_MAX) begin
              set[`CEACS_RI_RTO] = 1'b1;
              set[`CEACS_RI_DONE] = 1'b1;
              n.send_ccsd = 1'b0;
              n.auto_stop = 1'b0;
              n.state = ST_IDLE;
            end else begin
              n.wait_cnt = r.wait_cnt + 8'h01;
            end
          end else begin
            n.sh = rx;
            n.cnt = r.cnt + 8'h01;
            if (r.cnt < `CEACS_CRC_BITS) n.crc = ceacs_crc_step(r.crc, r.cmd_sync[1]);
            if (r.cnt + 8'h01 == ((r.state == ST_RESP && r.cmd[`CEACS_C_RESP_LONG]) ?
                `CEACS_LONG_BITS : `CEACS_FRAME_BITS)) begin
              n.resp = rx[39:8];
              if (r.state == ST_STOP_RESP) begin
                set[`CEACS_RI_ACD] = 1'b1;
                set[`CEACS_RI_DONE] = 1'b1;
                n.send_ccsd = 1'b0;
                n.auto_stop = 1'b0;
                n.state = ST_IDLE;
              end else begin
                if (r.cmd[`CEACS_C_CHK_CRC] && !r.cmd[`CEACS_C_RESP_LONG] &&
                    rx[7:1] != r.crc) set[`CEACS_RI_CRC_ERR] = 1'b1;
                if (r.cmd[`CEACS_C_DATA_EXP]) begin
                  n.data_start = 1'b1;
                  n.prv_busy = 1'b1;
                end
                if (r.cmd[`CEACS_C_CCS_EXP]) begin
                  n.state = ST_WAIT_CCS;
                end else begin
                  n.state = ST_IDLE;
                  set[`CEACS_RI_DONE] = 1'b1;
                end
              end
            end
          end
        end
      end
      ST_WAIT_CCS: begin
        if (r.send_ccsd) begin
          n.state = ST_CCSD;
          n.sh = `CEACS_CCSD_PAT;
          n.cnt = 8'h00;
        end else if (!r.prv_busy && !r.dat0_sync[1]) begin
          n.state = ST_IDLE;
          set[`CEACS_RI_CCS] = 1'b1;
          set[`CEACS_RI_DONE] = 1'b1;
        end
      end
    endcase
    n.rint = n.rint | set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rd_data;
  assign cmd_out = r.cmd_out;
  assign cmd_oe = r.cmd_oe;
  assign data_start = r.data_start;
  assign data_write = r.data_write;
  assign ceata_read = r.ceata_read;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_dir;
    data_start |=> data_write == $past(r.cmd[`CEACS_C_WRITE], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("data direction mismatch");

  property p_hold_prv;
    (r.state == ST_WAIT_PRV && r.prv_busy && !data_done) |=> r.state == ST_WAIT_PRV;
  endproperty
  a_hold_prv: assert property (p_hold_prv) else $error("command left wait early");

  property p_no_wait;
    (r.state == ST_IDLE && r.cmd[`CEACS_C_START] && !r.cmd[`CEACS_C_WAIT_PRV]) |=>
      r.state == ST_SEND;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("immediate command held");

  property p_crc_flag;
    $rose(r.rint[`CEACS_RI_CRC_ERR]) |-> $past(r.cmd[`CEACS_C_CHK_CRC]);
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc error without check");

  property p_ccsd_drive;
    (r.state == ST_WAIT_CCS && r.send_ccsd) |=> ##[1:20] cmd_oe && !cmd_out;
  endproperty
  a_ccsd_drive: assert property (p_ccsd_drive) else $error("disable pattern not sent");

  property p_acd;
    $rose(r.rint[`CEACS_RI_ACD]) |-> $past(r.state) == ST_STOP_RESP;
  endproperty
  a_acd: assert property (p_acd) else $error("auto-done without stop");

  property p_no_ccs_wait;
    (r.state == ST_RESP ##1 r.state == ST_WAIT_CCS) |-> $past(r.cmd[`CEACS_C_CCS_EXP]);
  endproperty
  a_no_ccs_wait: assert property (p_no_ccs_wait) else $error("ccs wait not expected");

  property p_ccs_hold;
    (r.state == ST_WAIT_CCS && !r.send_ccsd && (r.prv_busy || r.dat0_sync[1])) |=>
      !$rose(r.rint[`CEACS_RI_DONE]) && r.state == ST_WAIT_CCS;
  endproperty
  a_ccs_hold: assert property (p_ccs_hold) else $error("done before ccs");
endmodule // ceacs_sequencer
`default_nettype wire

// [ceacs_card_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ceacs_card_model (
  input wire logic cclk,
  input wire logic cmd_wire,
  input wire logic bad_crc,
  input wire logic slow,
  input wire logic ccs_now,
  input wire logic mute,
  output logic cmd_drv,
  output logic dat0,
  output logic [47:0] last_cmd,
  output logic [7:0] ccsd_cnt
);
  import ceacs_pkg::*;
  logic [47:0] f;
  assign dat0 = ~ccs_now;
  initial begin
    cmd_drv = 1'b1;
    last_cmd = '0;
    ccsd_cnt = '0;
    forever begin
      @(posedge cclk);
      if (cmd_wire === 1'b0) begin
        @(posedge cclk);
        if (cmd_wire === 1'b0) begin
          ccsd_cnt = ccsd_cnt + 8'h01;
          // Rest of the pattern is not a new frame
          while (cmd_wire !== 1'b1) @(posedge cclk);
        end else begin
          f = '0;
          f[46] = 1'b1;
          for (int i = 45; i >= 0; i--) begin
            @(posedge cclk);
            f[i] = cmd_wire;
          end
          last_cmd = f;
          if (!mute) begin
            repeat (slow ? 40 : 2) @(negedge cclk);
            f = ceacs_frame(f[45:40], 32'h0000_0900);
            f[1] = f[1] ^ bad_crc;
            for (int i = 47; i >= 0; i--) begin
              cmd_drv = f[i];
              @(negedge cclk);
            end
            cmd_drv = 1'b1;
          end
        end
      end
    end
  end
endmodule // ceacs_card_model
`default_nettype wire

// [tb_ceacs_sequencer.sv]
`include "ceacs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_ceacs_sequencer;
  import ceacs_pkg::*;
  localparam logic [31:0] TF = 32'h8000_0340;
  localparam logic [31:0] REG_C = 32'h0000_003C;
  localparam logic [31:0] BLK_C = 32'h0000_003D;
  logic clk, reset_n, wr_stb, rd_stb, cclk, data_done, bad_crc, slow, ccs_now, mute;
  logic cmd_out, cmd_oe, dat0, data_start, data_write, ceata_read, card_drv, cmd_wire;
  logic [7:0] addr, ccsd_cnt;
  logic [31:0] wdata, rdata, d, a;
  logic [47:0] last_cmd;
  int mismatches, comparisons, starts;
  assign cmd_wire = cmd_oe ? cmd_out : card_drv;
  ceacs_sequencer dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cclk(cclk), .cmd_in(cmd_wire),
    .cmd_out(cmd_out), .cmd_oe(cmd_oe), .dat0_in(dat0), .data_done(data_done),
    .data_start(data_start), .data_write(data_write), .ceata_read(ceata_read));
  ceacs_card_model card_u (.cclk(cclk), .cmd_wire(cmd_wire), .bad_crc(bad_crc),
    .slow(slow), .ccs_now(ccs_now), .mute(mute), .cmd_drv(card_drv), .dat0(dat0),
    .last_cmd(last_cmd), .ccsd_cnt(ccsd_cnt));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    cclk = 1'b0;
    #37;
    forever #100 cclk = ~cclk;
  end
  always @(posedge clk) begin
    if (data_start === 1'b1) starts++;
  end
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk);
    addr <= ad;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    addr <= ad;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic poll(input logic [7:0] ad, input logic [31:0] m);
    d = '0;
    for (int n = 0; n < 1500 && (d & m) !== m; n++) rd(ad);
  endtask
  task automatic launch(input logic [31:0] c, input logic [31:0] ag);
    wr(`CEACS_A_RINT, 32'h0000_003F);
    wr(`CEACS_A_ARG, ag);
    wr(`CEACS_A_CMD, c);
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] ag, input logic [31:0] m);
    launch(c, ag);
    poll(`CEACS_A_RINT, m);
    `CHK(d & m, m)
  endtask
  task automatic dto();
    @(posedge clk);
    data_done <= 1'b1;
    @(posedge clk);
    data_done <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("%0d mismatches in %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #1_500_000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {reset_n, wr_stb, rd_stb, data_done, bad_crc, slow, ccs_now, mute} = '0;
    addr = '0;
    wdata = '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wr(`CEACS_A_BLK, 32'hFFFF_0010);
    rd(`CEACS_A_BLK);
    `CHK(d, 32'h0000_0010)
    wr(`CEACS_A_BYT, 32'h0000_0010);
    rd(`CEACS_A_BYT);
    `CHK(d, 32'h0000_0010)
    rd(8'h40);
    `CHK(d, 32'h0000_0000)
    // Task-file read, then write
    for (int w = 0; w < 2; w++) begin
      a = {w[0], 31'h0000_0010};
      run(TF | REG_C | (w[0] ? 32'h0000_0400 : 32'h0040_0000), a, 32'h1);
      `CHK(last_cmd[47:8], {2'b01, REG_C[5:0], a})
      `CHK(data_write, w[0])
      `CHK(ceata_read, ~w[0])
      `CHK(starts, w + 1)
      rd(`CEACS_A_RESP);
      `CHK(d, 32'h0000_0900)
      dto();
    end
    // Held command while data is busy
    run(TF | BLK_C, 32'h0000_0001, 32'h1);
    launch(TF | 32'h0000_2000 | REG_C, 32'h0);
    poll(`CEACS_A_STAT, 32'h1);
    repeat (40) rd(`CEACS_A_STAT);
    `CHK(d[3:0], 4'h1)
    `CHK(cmd_oe, 1'b0)
    dto();
    poll(`CEACS_A_RINT, 32'h1);
    `CHK(d[0], 1'b1)
    run(TF | REG_C, 32'h0, 32'h1);
    dto();
    // Response check on and off
    bad_crc <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      run(32'h8000_0040 | REG_C | (k[0] ? 32'h0000_0100 : 32'h0), 32'h0, 32'h1);
      `CHK(d[1], k[0])
    end
    bad_crc <= 1'b0;
    // Silent card: command with no response, then a response timeout
    mute <= 1'b1;
    run(32'h8000_0000 | REG_C, 32'h0, 32'h1);
    `CHK(last_cmd[47:8], {2'b01, REG_C[5:0], 32'h0})
    run(32'h8000_0040 | REG_C, 32'h0, 32'h21);
    rd(`CEACS_A_STAT);
    `CHK(d[3:0], 4'h0)
    mute <= 1'b0;
    // Payload geometry, block read ended by an external stop
    wr(`CEACS_A_BLK, 32'h0000_0200);
    wr(`CEACS_A_BYT, 32'h0000_1000);
    rd(`CEACS_A_BLK);
    `CHK(d, 32'h0000_0200)
    run(TF | 32'h0040_0000 | BLK_C, 32'h0000_0001, 32'h1);
    run(32'h8000_014C, 32'h0, 32'h1);
    `CHK(last_cmd[47:8], {2'b01, 6'h0C, 32'h0})
    dto();
    // Completion held until the card signals
    launch(TF | 32'h00C0_0000 | BLK_C, 32'h0000_0001);
    poll(`CEACS_A_STAT, 32'h4);
    `CHK(d[3:0], 4'h4)
    `CHK(ceata_read, 1'b1)
    rd(`CEACS_A_RINT);
    `CHK(d[0], 1'b0)
    dto();
    @(posedge clk);
    ccs_now <= 1'b1;
    poll(`CEACS_A_RINT, 32'h11);
    `CHK(d[4] & d[0], 1'b1)
    @(posedge clk);
    ccs_now <= 1'b0;
    // Disable pattern alone closes the wait
    launch(TF | 32'h00C0_0000 | BLK_C, 32'h0000_0001);
    poll(`CEACS_A_STAT, 32'h4);
    wr(`CEACS_A_CTRL, 32'h0000_0001);
    poll(`CEACS_A_RINT, 32'h1);
    `CHK(d[2], 1'b0)
    `CHK(ccsd_cnt, 8'h01)
    // Disable pattern with internal stop, slow card
    slow <= 1'b1;
    launch(TF | 32'h00C0_0000 | BLK_C, 32'h0000_0001);
    poll(`CEACS_A_STAT, 32'h4);
    wr(`CEACS_A_CTRL, 32'h0000_0003);
    poll(`CEACS_A_RINT, 32'h4);
    `CHK(d[2], 1'b1)
    `CHK(ccsd_cnt, 8'h02)
    `CHK(last_cmd[47:8], {2'b01, 6'h0C, 32'h0})
    wrap_up();
  end
endmodule // tb_ceacs_sequencer
`default_nettype wire
